//--- gsr_status.sv
`timescale 1ns/1ns
// Behaviour
// - failed status is lamp fault or field fault
// - latched field fault reports zero duty
// - otherwise report filtered field duty
// - field terminal absent forces zero duty
// - latched field fault marks duty invalid if terminal fitted
// - field terminal absent always reports valid
// - status 1 s, lamp 500 ms, field 50 ms
// - key-on fails when duty high long enough
// - run test fails when duty low long enough
// - key-on time 1 to 125 s
// - run test only below speed limit
// - run time 1 to 125 s
// - one flag says field terminal fitted
// - first order lag, coefficient in 1/256
// - lamp key-on duty command 0 to 100 percent
// - lamp key-on time 1 to 125 s
// - average complete periods per field sample
module gsr_status #(
    parameter int FIELD_TICK_CYCLES = gsr_pkg::FIELD_TICK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        lamp_fault_detected,
    input  wire logic        field_fault_detected,
    input  wire logic        field_dtc_set,
    input  wire logic        field_period_done,
    input  wire logic [7:0]  field_period_duty,
    input  wire logic        field_keyon_enable,
    input  wire logic        field_run_enable,
    input  wire logic [13:0] engine_speed,
    input  wire logic        lamp_keyon_enable,
    input  wire logic        lamp_ground_seen,
    input  wire logic [6:0]  field_keyon_duty_threshold,
    input  wire logic [6:0]  field_run_duty_threshold,
    input  wire logic [6:0]  field_keyon_test_time,
    input  wire logic [6:0]  field_run_test_time,
    input  wire logic [8:0]  field_run_speed_limit,
    input  wire logic        field_terminal_fitted,
    input  wire logic [8:0]  field_lag_coefficient,
    input  wire logic [6:0]  lamp_keyon_command_duty,
    input  wire logic [6:0]  lamp_keyon_test_time,
    output logic             generator_failed,
    output logic [6:0]       field_duty_report,
    output logic             field_duty_valid,
    output logic [15:0]      filtered_field_duty,
    output logic             field_keyon_fail,
    output logic             field_run_fail,
    output logic             lamp_keyon_fail,
    output logic [6:0]       lamp_drive_duty
);

    typedef enum logic [1:0] {
        GSR_IDLE,
        GSR_DIVIDE,
        GSR_FILTER,
        GSR_TEST
    } gsr_phase_type;

    typedef struct packed {
        gsr_phase_type phase;
        logic [15:0]   acc_sum;
        logic [7:0]    acc_cnt;
        logic [15:0]   div_num;
        logic [7:0]    div_den;
        logic [8:0]    div_rem;
        logic [4:0]    div_step;
        logic [6:0]    sample;
        logic [15:0]   filt;
        logic [11:0]   keyon_timer;
        logic [11:0]   run_timer;
        logic [7:0]    lamp_timer;
        logic          keyon_fail;
        logic          run_fail;
        logic          lamp_fail;
        logic [6:0]    lamp_duty;
        logic          gen_failed;
        logic [6:0]    duty_report;
        logic          duty_valid;
    } gsr_state_type;

    gsr_tick_if ticks ();

    gsr_tick_gen #(
        .FIELD_TICK_CYCLES (FIELD_TICK_CYCLES)
    ) u_tick_gen (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ticks   (ticks)
    );

    gsr_state_type state_reg;
    gsr_state_type state_next;

    // out-of-range percent calibrations saturate rather than wrap
    function automatic logic [6:0] clamp_pct(input logic [7:0] pct);
        if (pct > {1'b0, gsr_pkg::PCT_MAX}) begin
            clamp_pct = gsr_pkg::PCT_MAX;
        end else begin
            clamp_pct = pct[6:0];
        end
    endfunction

    function automatic logic [6:0] clamp_time(input logic [6:0] secs);
        if (secs < gsr_pkg::TIME_MIN_S) begin
            clamp_time = gsr_pkg::TIME_MIN_S;
        end else if (secs > gsr_pkg::TIME_MAX_S) begin
            clamp_time = gsr_pkg::TIME_MAX_S;
        end else begin
            clamp_time = secs;
        end
    endfunction

    logic [6:0]         keyon_thr;
    logic [6:0]         run_thr;
    logic [11:0]        keyon_limit;
    logic [11:0]        run_limit;
    logic [7:0]         lamp_limit;
    logic [13:0]        speed_limit_rpm;
    logic [8:0]         coef;
    logic [6:0]         filt_pct;
    logic               keyon_active;
    logic               run_active;
    logic               field_latched;
    logic [8:0]         rem_shift;
    logic signed [16:0] diff;
    logic signed [26:0] prod;
    logic signed [17:0] filt_sum;
    logic [15:0]        acc_sum_base;
    logic [7:0]         acc_cnt_base;
    logic [6:0]         period_pct;

    localparam int COEF_SHIFT_HI = gsr_pkg::COEF_FRAC + 17;

    always_comb begin
        keyon_thr = clamp_pct({1'b0, field_keyon_duty_threshold});
        run_thr = clamp_pct({1'b0, field_run_duty_threshold});
        keyon_limit = 12'(clamp_time(field_keyon_test_time) * gsr_pkg::FIELD_TPS);
        run_limit = 12'(clamp_time(field_run_test_time) * gsr_pkg::FIELD_TPS);
        lamp_limit = 8'(clamp_time(lamp_keyon_test_time) * gsr_pkg::LAMP_TPS);
        speed_limit_rpm = 14'(field_run_speed_limit * gsr_pkg::RPM_STEP);
        if (field_lag_coefficient > gsr_pkg::COEF_ONE) begin
            coef = gsr_pkg::COEF_ONE;
        end else begin
            coef = field_lag_coefficient;
        end
        filt_pct = state_reg.filt[14:8];
        field_latched = field_fault_detected && field_dtc_set;
        keyon_active = field_terminal_fitted && field_keyon_enable
                       && !state_reg.run_fail;
        run_active = field_terminal_fitted && field_run_enable
                     && !state_reg.keyon_fail
                     && (engine_speed < speed_limit_rpm);
        rem_shift = {state_reg.div_rem[7:0], state_reg.div_num[15]};
        diff = $signed({1'b0, state_reg.sample, 8'h00})
               - $signed({1'b0, state_reg.filt});
        prod = diff * $signed({1'b0, coef});
        filt_sum = $signed({2'b00, state_reg.filt})
                   + $signed(prod[COEF_SHIFT_HI:gsr_pkg::COEF_FRAC]);
    end

    always_comb begin
        state_next = state_reg;
        acc_sum_base = state_reg.acc_sum;
        acc_cnt_base = state_reg.acc_cnt;
        period_pct = clamp_pct(field_period_duty);

        // a field tick starts a fresh averaging window
        if (ticks.field_tick && state_reg.phase == GSR_IDLE) begin
            acc_sum_base = 16'h0000;
            acc_cnt_base = 8'h00;
            if (state_reg.acc_cnt != 8'h00) begin
                state_next.div_num = state_reg.acc_sum;
                state_next.div_den = state_reg.acc_cnt;
                state_next.div_rem = 9'h000;
                state_next.div_step = 5'h00;
                state_next.phase = GSR_DIVIDE;
            end else begin
                // no complete period seen: previous average is reused
                state_next.phase = GSR_FILTER;
            end
        end

        // periods past the counter limit are dropped from the window
        if (field_period_done && acc_cnt_base != gsr_pkg::ACC_CNT_MAX) begin
            state_next.acc_sum = acc_sum_base + {9'h000, period_pct};
            state_next.acc_cnt = acc_cnt_base + 8'h01;
        end else begin
            state_next.acc_sum = acc_sum_base;
            state_next.acc_cnt = acc_cnt_base;
        end

        case (state_reg.phase)
            GSR_IDLE: begin
            end
            GSR_DIVIDE: begin
                // restoring divide, one quotient bit per cycle
                if (rem_shift >= {1'b0, state_reg.div_den}) begin
                    state_next.div_rem = rem_shift - {1'b0, state_reg.div_den};
                    state_next.div_num = {state_reg.div_num[14:0], 1'b1};
                end else begin
                    state_next.div_rem = rem_shift;
                    state_next.div_num = {state_reg.div_num[14:0], 1'b0};
                end
                state_next.div_step = state_reg.div_step + 5'h01;
                if (state_reg.div_step == 5'(gsr_pkg::DIV_STEPS - 1)) begin
                    state_next.phase = GSR_FILTER;
                end
            end
            GSR_FILTER: begin
                if (state_reg.div_step == 5'(gsr_pkg::DIV_STEPS)) begin
                    state_next.sample = clamp_pct(state_reg.div_num[7:0]);
                    state_next.div_step = 5'h00;
                end
                state_next.phase = GSR_TEST;
            end
            GSR_TEST: begin
                state_next.phase = GSR_IDLE;
            end
            default: begin
                state_next.phase = GSR_IDLE;
            end
        endcase

        // lag filter applied once the new average is in place
        if (state_reg.phase == GSR_TEST) begin
            state_next.filt = filt_sum[15:0];
        end

        // field timers advance in the test phase after each field tick, using the filtered value held before this update
        if (state_reg.phase == GSR_TEST) begin
            if (keyon_active && filt_pct >= keyon_thr) begin
                if (state_reg.keyon_timer != 12'hfff) begin
                    state_next.keyon_timer = state_reg.keyon_timer + 12'h001;
                end
            end else begin
                state_next.keyon_timer = 12'h000;
            end
            if (run_active && filt_pct <= run_thr) begin
                if (state_reg.run_timer != 12'hfff) begin
                    state_next.run_timer = state_reg.run_timer + 12'h001;
                end
            end else begin
                state_next.run_timer = 12'h000;
            end
        end
        state_next.keyon_fail = (state_reg.keyon_timer >= keyon_limit);
        state_next.run_fail = (state_reg.run_timer >= run_limit);

        // lamp key-on test: ground never seen while the output is on
        if (ticks.lamp_tick) begin
            if (lamp_keyon_enable && !lamp_ground_seen) begin
                if (state_reg.lamp_timer != 8'hff) begin
                    state_next.lamp_timer = state_reg.lamp_timer + 8'h01;
                end
            end else begin
                state_next.lamp_timer = 8'h00;
            end
        end
        state_next.lamp_fail = (state_reg.lamp_timer >= lamp_limit);
        if (lamp_keyon_enable) begin
            state_next.lamp_duty = clamp_pct({1'b0, lamp_keyon_command_duty});
        end else begin
            state_next.lamp_duty = gsr_pkg::PCT_ZERO;
        end

        // network status refreshed only on the status tick
        if (ticks.status_tick) begin
            state_next.gen_failed = lamp_fault_detected || field_fault_detected;
            if (!field_terminal_fitted) begin
                state_next.duty_report = gsr_pkg::PCT_ZERO;
                state_next.duty_valid = 1'b1;
            end else if (field_latched) begin
                state_next.duty_report = gsr_pkg::PCT_ZERO;
                state_next.duty_valid = 1'b0;
            end else begin
                state_next.duty_report = filt_pct;
                state_next.duty_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.phase <= GSR_IDLE;
            state_reg.gen_failed <= gsr_pkg::GEN_FAILED_RST;
            state_reg.duty_report <= gsr_pkg::DUTY_REPORT_RST;
            state_reg.duty_valid <= gsr_pkg::DUTY_VALID_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign generator_failed = state_reg.gen_failed;
    assign field_duty_report = state_reg.duty_report;
    assign field_duty_valid = state_reg.duty_valid;
    assign filtered_field_duty = state_reg.filt;
    assign field_keyon_fail = state_reg.keyon_fail;
    assign field_run_fail = state_reg.run_fail;
    assign lamp_keyon_fail = state_reg.lamp_fail;
    assign lamp_drive_duty = state_reg.lamp_duty;

endmodule

//--- gsr_pkg.sv
package gsr_pkg;

    // clock and execution intervals
    localparam int CLK_FREQ_HZ         = 250_000_000;
    localparam int MS_PER_S            = 1000;
    localparam int FIELD_INTERVAL_MS   = 50;
    localparam int LAMP_INTERVAL_MS    = 500;
    localparam int STATUS_INTERVAL_MS  = 1000;
    // shortest interval: integer division rounds down
    localparam int FIELD_TICK_CYCLES   = (CLK_FREQ_HZ / MS_PER_S) * FIELD_INTERVAL_MS;
    localparam int LAMP_PER_FIELD      = LAMP_INTERVAL_MS / FIELD_INTERVAL_MS;
    localparam int STATUS_PER_FIELD    = STATUS_INTERVAL_MS / FIELD_INTERVAL_MS;
    localparam int FIELD_TICKS_PER_S   = MS_PER_S / FIELD_INTERVAL_MS;
    localparam int LAMP_TICKS_PER_S    = MS_PER_S / LAMP_INTERVAL_MS;

    // calibration ranges
    localparam logic [6:0] PCT_MAX     = 7'h64;
    localparam logic [6:0] PCT_ZERO    = 7'h00;
    localparam logic [6:0] TIME_MIN_S  = 7'h01;
    localparam logic [6:0] TIME_MAX_S  = 7'h7d;
    localparam logic [4:0] RPM_STEP    = 5'h19;
    localparam logic [8:0] COEF_ONE    = 9'h100;
    localparam int         COEF_FRAC   = 8;

    // field and lamp timer scaling
    localparam logic [4:0] FIELD_TPS   = 5'(FIELD_TICKS_PER_S);
    localparam logic [1:0] LAMP_TPS    = 2'(LAMP_TICKS_PER_S);

    // reset values of the network outputs
    localparam logic       GEN_FAILED_RST  = 1'b0;
    localparam logic [6:0] DUTY_REPORT_RST = 7'h00;
    localparam logic       DUTY_VALID_RST  = 1'b1;

    // averaging accumulator limits
    localparam logic [7:0] ACC_CNT_MAX = 8'hff;
    localparam int         DIV_STEPS   = 16;

endpackage

//--- gsr_tick_if.sv
`timescale 1ns/1ns
interface gsr_tick_if;
    logic field_tick;
    logic lamp_tick;
    logic status_tick;

    modport gen (
        output field_tick,
        output lamp_tick,
        output status_tick
    );
    modport user (
        input field_tick,
        input lamp_tick,
        input status_tick
    );
endinterface

//--- gsr_tick_gen.sv
`timescale 1ns/1ns
module gsr_tick_gen #(
    parameter int FIELD_TICK_CYCLES = gsr_pkg::FIELD_TICK_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    gsr_tick_if.gen   ticks
);
    localparam int CNT_W = $clog2(FIELD_TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FIELD_TICK_CYCLES - 1);
    localparam logic [4:0] LAMP_LAST = 5'(gsr_pkg::LAMP_PER_FIELD - 1);
    localparam logic [4:0] STAT_LAST = 5'(gsr_pkg::STATUS_PER_FIELD - 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [4:0]       lamp_div;
        logic [4:0]       stat_div;
        logic             field_tick;
        logic             lamp_tick;
        logic             status_tick;
    } gsr_tick_state_type;

    gsr_tick_state_type state_reg;
    gsr_tick_state_type state_next;

    // slower ticks derive from the field tick so all three stay phase locked
    always_comb begin
        state_next = state_reg;
        state_next.field_tick = 1'b0;
        state_next.lamp_tick = 1'b0;
        state_next.status_tick = 1'b0;
        if (state_reg.cnt == CNT_LAST) begin
            state_next.cnt = '0;
            state_next.field_tick = 1'b1;
            if (state_reg.lamp_div == LAMP_LAST) begin
                state_next.lamp_div = 5'h00;
                state_next.lamp_tick = 1'b1;
            end else begin
                state_next.lamp_div = state_reg.lamp_div + 5'h01;
            end
            if (state_reg.stat_div == STAT_LAST) begin
                state_next.stat_div = 5'h00;
                state_next.status_tick = 1'b1;
            end else begin
                state_next.stat_div = state_reg.stat_div + 5'h01;
            end
        end else begin
            state_next.cnt = state_reg.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ticks.field_tick = state_reg.field_tick;
    assign ticks.lamp_tick = state_reg.lamp_tick;
    assign ticks.status_tick = state_reg.status_tick;
endmodule

//--- gsr_status_props.sv
`timescale 1ns/1ns
module gsr_status_props #(
    parameter int FIELD_TICK_CYCLES = 64
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        lamp_fault_detected,
    input wire logic        field_fault_detected,
    input wire logic        field_dtc_set,
    input wire logic        field_terminal_fitted,
    input wire logic        field_keyon_enable,
    input wire logic        field_run_enable,
    input wire logic [13:0] engine_speed,
    input wire logic [8:0]  field_run_speed_limit,
    input wire logic        lamp_keyon_enable,
    input wire logic [6:0]  lamp_keyon_command_duty,
    input wire logic        generator_failed,
    input wire logic [6:0]  field_duty_report,
    input wire logic        field_duty_valid,
    input wire logic [15:0] filtered_field_duty,
    input wire logic        field_keyon_fail,
    input wire logic        field_run_fail,
    input wire logic [6:0]  lamp_drive_duty
);
    // inputs must be steady over two edges, as the sampling edge is hidden
    logic       fails_in;
    logic       latched;
    logic       fit2;
    logic [8:0] status_bus;
    assign fails_in   = lamp_fault_detected | field_fault_detected;
    assign latched    = field_fault_detected & field_dtc_set;
    assign status_bus = {generator_failed, field_duty_valid, field_duty_report};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_hold(sig);
        ##1 $stable(sig) [*8];
    endsequence
    sequence s_fit_steady(v);
        $past(field_terminal_fitted) == v && $past(field_terminal_fitted, 2) == v;
    endsequence

    property p_failed_src;
        $changed(generator_failed) && $past(fails_in) == $past(fails_in, 2)
        |-> generator_failed == $past(fails_in);
    endproperty
    property p_duty_absent;
        $changed(status_bus) ##0 s_fit_steady(1'b0)
        |-> field_duty_report == 7'h00 && field_duty_valid;
    endproperty
    property p_duty_fault;
        $changed(status_bus) && $past(latched) && $past(latched, 2) ##0 s_fit_steady(1'b1)
        |-> field_duty_report == 7'h00 && !field_duty_valid;
    endproperty
    property p_duty_follow;
        $changed(field_duty_report) && !$past(latched) && !$past(latched, 2)
        ##0 s_fit_steady(1'b1)
        |-> field_duty_report == $past(filtered_field_duty[14:8]) && field_duty_valid;
    endproperty
    property p_status_hold;
        $changed(status_bus) |-> s_hold(status_bus);
    endproperty
    property p_filt_hold;
        $changed(filtered_field_duty) |-> s_hold(filtered_field_duty);
    endproperty
    property p_filt_range;
        filtered_field_duty <= 16'h6400;
    endproperty
    property p_keyon_cause;
        $rose(field_keyon_fail)
        |-> $past(field_terminal_fitted, 2) && $past(field_keyon_enable, 2);
    endproperty
    property p_keyon_drop;
        $fell(field_keyon_enable) |-> ##[0:100] !field_keyon_fail;
    endproperty
    property p_run_cause;
        $rose(field_run_fail) |-> $past(field_run_enable, 2)
            && $past(engine_speed, 2) < 14'($past(field_run_speed_limit, 2)) * 14'h0019;
    endproperty
    property p_lamp_drive;
        $past(lamp_keyon_enable) && $past(lamp_keyon_command_duty) <= 7'h64
        |-> lamp_drive_duty == $past(lamp_keyon_command_duty);
    endproperty

    a_failed_src: assert property (p_failed_src) else $error("failed flag wrong");
    a_duty_absent: assert property (p_duty_absent) else $error("absent duty");
    a_duty_fault: assert property (p_duty_fault) else $error("fault duty");
    a_duty_follow: assert property (p_duty_follow) else $error("duty follow");
    a_status_hold: assert property (p_status_hold) else $error("status moved");
    a_filt_hold: assert property (p_filt_hold) else $error("filter rate");
    a_filt_range: assert property (p_filt_range) else $error("filter range");
    a_keyon_cause: assert property (p_keyon_cause) else $error("keyon cause");
    a_keyon_drop: assert property (p_keyon_drop) else $error("keyon stuck");
    a_run_cause: assert property (p_run_cause) else $error("run cause");
    a_lamp_drive: assert property (p_lamp_drive) else $error("lamp drive");
endmodule

bind gsr_status gsr_status_props #(.FIELD_TICK_CYCLES(FIELD_TICK_CYCLES)) gsr_status_props_i (.*);

//--- gsr_net_rx.sv
`timescale 1ns/1ns
module gsr_net_rx (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       generator_failed,
    input  wire logic [6:0] field_duty_report,
    input  wire logic       field_duty_valid,
    output logic            rx_failed,
    output logic [6:0]      rx_duty,
    output logic            rx_valid
);
    // a node keeps the last frame it saw; no frame framing modelled
    typedef struct packed {
        logic       failed;
        logic [6:0] duty;
        logic       valid;
    } gsr_rx_type;
    gsr_rx_type rx_reg;
    gsr_rx_type rx_next;
    always_comb begin
        rx_next = '{generator_failed, field_duty_report, field_duty_valid};
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_reg <= '{1'b0, 7'h00, 1'b1};
        end else begin
            rx_reg <= rx_next;
        end
    end
    assign rx_failed = rx_reg.failed;
    assign rx_duty   = rx_reg.duty;
    assign rx_valid  = rx_reg.valid;
endmodule

//--- gsr_status_tb_top.sv
`timescale 1ns/1ns
module gsr_status_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        lamp_fault_detected, field_fault_detected, field_dtc_set;
    logic        field_period_done = 1'b0;
    logic [7:0]  field_period_duty = 8'h00;
    logic        field_keyon_enable, field_run_enable, lamp_keyon_enable, lamp_ground_seen;
    logic [13:0] engine_speed;
    logic [6:0]  field_keyon_duty_threshold, field_run_duty_threshold;
    logic [6:0]  field_keyon_test_time, field_run_test_time, lamp_keyon_test_time;
    logic [8:0]  field_run_speed_limit, field_lag_coefficient;
    logic        field_terminal_fitted;
    logic [6:0]  lamp_keyon_command_duty, field_duty_report, lamp_drive_duty, rx_duty;
    logic        generator_failed, field_duty_valid, rx_failed, rx_valid;
    logic        field_keyon_fail, field_run_fail, lamp_keyon_fail;
    logic [15:0] filtered_field_duty;
    logic [6:0]  duty_now = 7'h00;
    logic [2:0]  pulse_cnt = 3'h0;
    logic [6:0]  ex_duty;
    int          err_total = 0;
    int          checks_done = 0;
    int          seed = 32'h9111_74e0;

    always #2 sys_clk = ~sys_clk;

    gsr_status #(.FIELD_TICK_CYCLES(64)) gsr_status_i (.*);
    gsr_net_rx gsr_net_rx_i (.*);

    // one complete field period every 8 cycles at the chosen duty
    always @(posedge sys_clk) begin
        pulse_cnt <= pulse_cnt + 3'h1;
        field_period_done <= pulse_cnt == 3'h7;
        field_period_duty <= {1'b0, duty_now};
    end

    function automatic logic [6:0] exp_duty(logic fit, logic ff, logic dtc, logic [6:0] d);
        return (!fit || (ff && dtc)) ? 7'h00 : d;
    endfunction

    task automatic run(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check_word(logic [15:0] got, logic [15:0] exp, string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic check_bit(logic got, logic exp, string what);
        check_word({15'h0000, got}, {15'h0000, exp}, what);
    endtask
    task automatic set_status(logic fit, logic lf, logic ff, logic dtc, logic [6:0] d);
        @(posedge sys_clk);
        field_terminal_fitted <= fit;
        lamp_fault_detected <= lf;
        field_fault_detected <= ff;
        field_dtc_set <= dtc;
        duty_now <= d;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #400000;
        err_total++;
        report_and_stop;
    end

    initial begin
        {lamp_fault_detected, field_fault_detected, field_dtc_set} = 3'h0;
        {field_keyon_enable, field_run_enable, lamp_keyon_enable, lamp_ground_seen} = 4'h0;
        engine_speed = 14'h0000;
        field_terminal_fitted = 1'b1;
        field_keyon_duty_threshold = 7'h41;
        field_run_duty_threshold = 7'h05;
        field_keyon_test_time = 7'h02;
        field_run_test_time = 7'h01;
        lamp_keyon_test_time = 7'h01;
        field_run_speed_limit = 9'h028;
        field_lag_coefficient = 9'h100;
        lamp_keyon_command_duty = 7'h00;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        run(1);
        check_word({generator_failed, field_duty_valid, field_keyon_fail, field_run_fail,
                    lamp_keyon_fail, field_duty_report}, 16'h0400, "reset outputs");
        for (int i = 0; i < 8; i++) begin
            if (i == 0) set_status(1'b0, 1'b0, 1'b1, 1'b1, 7'h64);
            else if (i == 1) set_status(1'b1, 1'b0, 1'b1, 1'b1, 7'h00);
            else if (i == 2) set_status(1'b1, 1'b1, 1'b1, 1'b0, 7'h64);
            else set_status(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                            1'($random(seed)), 7'($unsigned($random(seed)) % 101));
            run(2700);
            ex_duty = exp_duty(field_terminal_fitted, field_fault_detected, field_dtc_set, duty_now);
            check_bit(generator_failed, lamp_fault_detected | field_fault_detected, "failed");
            check_word(16'(field_duty_report), 16'(ex_duty), "duty");
            check_bit(field_duty_valid, !(field_terminal_fitted && field_fault_detected
                      && field_dtc_set), "valid");
            check_word(filtered_field_duty, {1'b0, duty_now, 8'h00}, "filter");
            check_word({7'h00, rx_failed, rx_valid, rx_duty}, {7'h00, generator_failed,
                       field_duty_valid, ex_duty}, "node view");
            $display("status case %0d done", i);
        end
        // key-on: boundary duty equal to threshold, absent terminal blocks it
        set_status(1'b0, 1'b0, 1'b0, 1'b0, 7'h41);
        field_keyon_enable <= 1'b1;
        run(3300);
        check_bit(field_keyon_fail, 1'b0, "keyon unfitted");
        set_status(1'b1, 1'b0, 1'b0, 1'b0, 7'h41);
        run(1800);
        check_bit(field_keyon_fail, 1'b0, "keyon early");
        run(1500);
        check_bit(field_keyon_fail, 1'b1, "keyon late");
        field_keyon_enable <= 1'b0;
        run(300);
        check_bit(field_keyon_fail, 1'b0, "keyon drop");
        $display("keyon test done");
        // run test: 975 rpm is below 40 steps of 25, 1000 rpm is not
        set_status(1'b1, 1'b0, 1'b0, 1'b0, 7'h05);
        engine_speed <= 14'h03cf;
        field_run_enable <= 1'b1;
        run(1800);
        check_bit(field_run_fail, 1'b1, "run fail");
        engine_speed <= 14'h03e8;
        run(300);
        check_bit(field_run_fail, 1'b0, "run speed");
        $display("run test done");
        lamp_keyon_command_duty <= 7'($unsigned($random(seed)) % 101);
        lamp_keyon_enable <= 1'b1;
        run(3);
        check_word(16'(lamp_drive_duty), 16'(lamp_keyon_command_duty), "lamp duty");
        run(500);
        check_bit(lamp_keyon_fail, 1'b0, "lamp early");
        run(1500);
        check_bit(lamp_keyon_fail, 1'b1, "lamp late");
        lamp_ground_seen <= 1'b1;
        run(700);
        check_bit(lamp_keyon_fail, 1'b0, "lamp ground");
        $display("lamp test done");
        report_and_stop;
    end
endmodule
